// File: hw/plc_regs.svh
// Timing and sizing constants of the pulse link port controller
`ifndef PLC_REGS_SVH
`define PLC_REGS_SVH

// ----------------------------------------------------------------
// Clock and symbol timing
// ----------------------------------------------------------------
`define PLC_CLK_NS 20
`define PLC_LONG_HALF_NS 150
`define PLC_SHORT_HALF_NS 50
`define PLC_DWELL_NS 240
`define PLC_LONG_HALF_CYC ((`PLC_LONG_HALF_NS + `PLC_CLK_NS - 1) / `PLC_CLK_NS)
`define PLC_SHORT_HALF_CYC ((`PLC_SHORT_HALF_NS + `PLC_CLK_NS - 1) / `PLC_CLK_NS)
`define PLC_DWELL_CYC ((`PLC_DWELL_NS + `PLC_CLK_NS - 1) / `PLC_CLK_NS)
`define PLC_LONG_MIN_CYC ((`PLC_LONG_HALF_CYC + `PLC_SHORT_HALF_CYC) / 2)

// ----------------------------------------------------------------
// Framing and buffering
// ----------------------------------------------------------------
`define PLC_CMD_CODE_BITS 16
`define PLC_CHECK_CODE_BITS 16
`define PLC_CMD_BITS (`PLC_CMD_CODE_BITS + `PLC_CHECK_CODE_BITS)
`define PLC_FIFO_WIDTH 2
`define PLC_FIFO_DEPTH 8

`endif

// File: hw/plc_pkg.sv
// Types and symbol helpers
package plc_pkg;

  typedef enum logic [1:0] {
    plc_long_pos = 2'h0,
    plc_long_neg = 2'h1,
    plc_short_pos = 2'h2,
    plc_short_neg = 2'h3
  } plc_sym_type;

  typedef enum logic [1:0] {
    plc_st_idle = 2'h0,
    plc_st_waking = 2'h1,
    plc_st_ready = 2'h2,
    plc_st_active = 2'h3
  } plc_state_type;

  typedef enum logic [1:0] {
    plc_tx_off = 2'h0,
    plc_tx_first = 2'h1,
    plc_tx_second = 2'h2
  } plc_tx_phase_type;

  function automatic logic plc_is_long(input plc_sym_type kind);
    return (kind == plc_long_pos) || (kind == plc_long_neg);
  endfunction : plc_is_long

  function automatic logic plc_is_pos(input plc_sym_type kind);
    return (kind == plc_long_pos) || (kind == plc_short_pos);
  endfunction : plc_is_pos

  function automatic plc_sym_type plc_make_sym(input logic is_long, input logic is_pos);
    if (is_long) begin
      return is_pos ? plc_long_pos : plc_long_neg;
    end
    return is_pos ? plc_short_pos : plc_short_neg;
  endfunction : plc_make_sym

endpackage : plc_pkg

// File: hw/plc_sym_if.sv
// Symbol hand-off between the controller and a port transmitter
`timescale 1ns/1ns
interface plc_sym_if;
  import plc_pkg::*;
  logic valid;
  plc_sym_type kind;
  logic ready;
  logic busy;
  modport src (output valid, output kind, input ready, input busy);
  modport snk (input valid, input kind, output ready, output busy);
endinterface : plc_sym_if

// File: hw/plc_sym_fifo.sv
// Parameterised FIFO for outgoing symbols
`timescale 1ns/1ns
module plc_sym_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic full;
  logic empty;

  assign empty = (wr_ptr == rd_ptr);
  assign full = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge ref_clk) begin
    if (in_valid && !full) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (in_valid && !full) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (out_ready && !empty) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule : plc_sym_fifo

// File: hw/plc_sym_tx.sv
// Differential pulse symbol transmitter for one port
`timescale 1ns/1ns
`include "plc_regs.svh"
module plc_sym_tx
  import plc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Symbol input
  plc_sym_if.snk sym,
  // Line drive
  output logic line_p,
  output logic line_n,
  output logic line_oe
);
  plc_tx_phase_type phase;
  logic [3:0] cnt;
  logic is_long;

  assign sym.ready = (phase == plc_tx_off);
  assign sym.busy = (phase != plc_tx_off);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      phase <= plc_tx_off;
      cnt <= 4'h0;
      is_long <= 1'b0;
      line_p <= 1'b0;
      line_n <= 1'b0;
      line_oe <= 1'b0;
    end else begin
      case (phase)
        plc_tx_off: begin
          if (sym.valid) begin
            phase <= plc_tx_first;
            is_long <= plc_is_long(sym.kind);
            line_p <= plc_is_pos(sym.kind);
            line_n <= !plc_is_pos(sym.kind);
            line_oe <= 1'b1;
            cnt <= plc_is_long(sym.kind) ? 4'(`PLC_LONG_HALF_CYC - 1)
                                         : 4'(`PLC_SHORT_HALF_CYC - 1);
          end
        end
        plc_tx_first: begin
          if (cnt == 4'h0) begin
            // Opposite second half keeps the symbol DC free
            phase <= plc_tx_second;
            line_p <= line_n;
            line_n <= line_p;
            cnt <= is_long ? 4'(`PLC_LONG_HALF_CYC - 1) : 4'(`PLC_SHORT_HALF_CYC - 1);
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        plc_tx_second: begin
          if (cnt == 4'h0) begin
            phase <= plc_tx_off;
            line_p <= 1'b0;
            line_n <= 1'b0;
            line_oe <= 1'b0;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        default: begin
          phase <= plc_tx_off;
        end
      endcase
    end
  end
endmodule : plc_sym_tx

// File: hw/plc_port_ctrl.sv
// Two-port pulse link controller
`timescale 1ns/1ns
`include "plc_regs.svh"

// Behaviour
// - Four-wire mode: select edges become long pulses, clock rises short pulses on B.
// - Slave drives internal select from long pulses; short pulses set data then clock.
// - In read, answer each short pulse with short negative when bit is 0.
// - Slave port transmits only short negative pulses.
// - Master reads a missing return pulse in a bit slot as 1.
// - Asleep, valid wake-up on either port wakes, whatever the port A mode.
// - Woken via port A: send long positive on B once ready; not via B.
// - Ready, pulse mode: port receiving long negative becomes slave, other master.
// - Active holds internal select low; long positive on slave returns to ready.
// - Active: long negative on master after blocking time swaps port roles.
// - Long pulses on master within blocking time after transmission are rejected.
// - After 32 command and check bits, read decode begins shifting data.
// - Read data leaves bottom device, own data first, then higher devices.
// - Ports go idle after no activity for the idle timeout.
// - Wake on select or clock in four-wire mode, differential activity otherwise.
// - Wake needs differential level held for the dwell time; common mode ignored.
// - Ready reached after wake time or ready time, per core sleep or standby.
// - A device already ready does not propagate a wake pulse.
// - Symbols are two opposite halves, 150ns long or 50ns short, ending at zero.
// - Four-wire mode fixes port A as slave and port B as master.
// - Bytes of 8 bits, most significant first; select low across the command.
module plc_port_ctrl
  import plc_pkg::*;
#(
  parameter int IDLE_CYCLES = 250000,
  parameter int WAKE_CYCLES = 20000,
  parameter int READY_CYCLES = 500,
  parameter int BLOCK_CYCLES = 100
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Port A pulse lines
  input wire logic port_a_pos_line_in,
  output logic port_a_pos_line_out,
  output logic port_a_pos_line_oe,
  input wire logic port_a_neg_line_in,
  output logic port_a_neg_line_out,
  output logic port_a_neg_line_oe,
  // Port B pulse lines
  input wire logic port_b_pos_line_in,
  output logic port_b_pos_line_out,
  output logic port_b_pos_line_oe,
  input wire logic port_b_neg_line_in,
  output logic port_b_neg_line_out,
  output logic port_b_neg_line_oe,
  // Port A four-wire pins and mode strap
  input wire logic port_a_mode_select,
  input wire logic select_bar,
  input wire logic serial_clk,
  input wire logic serial_in,
  output logic serial_out,
  // Internal serial bus toward the core
  output logic int_select_bar,
  output logic int_clk,
  output logic int_data,
  input wire logic core_standby,
  input wire logic core_read_cmd,
  input wire logic core_read_more,
  input wire logic core_read_bit,
  // Status
  output logic [1:0] link_state,
  output logic slave_on_b,
  output logic sym_dropped
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [7:0] pin_meta;
  logic [7:0] pin_sync;
  logic [7:0] pin_prev;
  logic four_wire;
  logic sel_fall;
  logic sel_rise;
  logic clk_rise;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pin_meta <= 8'h90;
      pin_sync <= 8'h90;
      pin_prev <= 8'h90;
    end else begin
      pin_meta <= {port_a_mode_select, serial_in, serial_clk, select_bar,
                   port_b_neg_line_in, port_b_pos_line_in,
                   port_a_neg_line_in, port_a_pos_line_in};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  assign four_wire = !pin_sync[7];
  assign sel_fall = four_wire && pin_prev[4] && !pin_sync[4];
  assign sel_rise = four_wire && !pin_prev[4] && pin_sync[4];
  assign clk_rise = four_wire && !pin_prev[5] && pin_sync[5];

  // ----------------------------------------------------------------
  // Pulse receivers and wake detectors
  // ----------------------------------------------------------------
  logic [1:0] lvl_pos;
  logic [1:0] lvl_neg;
  logic [1:0] rx_run;
  logic [1:0] rx_pol;
  logic [1:0] rx_evt;
  logic [1:0] rx_long;
  logic [1:0] rx_sym_pos;
  logic [1:0] wake_hit;
  logic [1:0] tx_busy;
  logic [3:0] rx_cnt [2];
  logic [3:0] act_cnt [2];

  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_rx
      // Equal levels are common mode
      assign lvl_pos[p] = pin_sync[2*p] && !pin_sync[2*p+1];
      assign lvl_neg[p] = pin_sync[2*p+1] && !pin_sync[2*p];

      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          rx_run[p] <= 1'b0;
          rx_pol[p] <= 1'b0;
          rx_cnt[p] <= 4'h0;
          rx_evt[p] <= 1'b0;
          rx_long[p] <= 1'b0;
          rx_sym_pos[p] <= 1'b0;
        end else begin
          rx_evt[p] <= 1'b0;
          if (!rx_run[p]) begin
            if ((lvl_pos[p] || lvl_neg[p]) && !tx_busy[p]) begin
              rx_run[p] <= 1'b1;
              rx_pol[p] <= lvl_pos[p];
              rx_cnt[p] <= 4'h1;
            end
          end else if ((rx_pol[p] && lvl_pos[p]) || (!rx_pol[p] && lvl_neg[p])) begin
            if (rx_cnt[p] != 4'hf) begin
              rx_cnt[p] <= rx_cnt[p] + 4'h1;
            end
          end else begin
            // Opposite half ends a symbol; zero drops it
            rx_run[p] <= 1'b0;
            if (lvl_pos[p] || lvl_neg[p]) begin
              rx_evt[p] <= 1'b1;
              rx_long[p] <= (rx_cnt[p] >= 4'(`PLC_LONG_MIN_CYC));
              rx_sym_pos[p] <= rx_pol[p];
            end
          end
        end
      end

      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          act_cnt[p] <= 4'h0;
          wake_hit[p] <= 1'b0;
        end else begin
          wake_hit[p] <= (lvl_pos[p] || lvl_neg[p])
                         && (act_cnt[p] == 4'(`PLC_DWELL_CYC - 1));
          if (!(lvl_pos[p] || lvl_neg[p])) begin
            act_cnt[p] <= 4'h0;
          end else if (act_cnt[p] != 4'hf) begin
            act_cnt[p] <= act_cnt[p] + 4'h1;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Event decode and forwarding
  // ----------------------------------------------------------------
  plc_state_type state;
  logic slave_is_b;
  logic wake_from_a;
  logic [19:0] timer;
  logic [19:0] idle_cnt;
  logic [19:0] blk_cnt;
  logic wake_done;
  logic wake_any;
  logic sl_evt;
  plc_sym_type sl_kind;
  logic start_a;
  logic start_b;
  logic ms_evt;
  logic ms_long;
  logic ms_pos;
  logic swap_ok;
  logic push_valid;
  logic push_ready;
  plc_sym_type push_kind;

  assign wake_done = core_standby ? (timer >= 20'(READY_CYCLES - 1))
                                  : (timer >= 20'(WAKE_CYCLES - 1));
  assign wake_any = (four_wire && (sel_fall || sel_rise || clk_rise))
                    || wake_hit[1] || (!four_wire && wake_hit[0]);
  assign start_a = rx_evt[0] && rx_long[0] && !rx_sym_pos[0];
  assign start_b = rx_evt[1] && rx_long[1] && !rx_sym_pos[1];
  assign ms_evt = slave_is_b ? rx_evt[0] : rx_evt[1];
  assign ms_long = slave_is_b ? rx_long[0] : rx_long[1];
  assign ms_pos = slave_is_b ? rx_sym_pos[0] : rx_sym_pos[1];
  assign swap_ok = blk_cnt >= 20'(BLOCK_CYCLES);

  always_comb begin
    sl_evt = 1'b0;
    sl_kind = plc_long_pos;
    if (four_wire) begin
      if (sel_fall) begin
        sl_evt = 1'b1;
        sl_kind = plc_long_neg;
      end else if (sel_rise) begin
        sl_evt = 1'b1;
        sl_kind = plc_long_pos;
      end else if (clk_rise) begin
        sl_evt = 1'b1;
        sl_kind = pin_sync[6] ? plc_short_pos : plc_short_neg;
      end
    end else if (slave_is_b ? rx_evt[1] : rx_evt[0]) begin
      sl_evt = 1'b1;
      sl_kind = slave_is_b ? plc_make_sym(rx_long[1], rx_sym_pos[1])
                           : plc_make_sym(rx_long[0], rx_sym_pos[0]);
    end
  end

  always_comb begin
    push_valid = 1'b0;
    push_kind = plc_long_pos;
    case (state)
      plc_st_waking: begin
        push_valid = wake_done && wake_from_a;
      end
      plc_st_ready: begin
        if ((four_wire && sel_fall) || (!four_wire && (start_a || start_b))) begin
          push_valid = 1'b1;
          push_kind = plc_long_neg;
        end
      end
      plc_st_active: begin
        push_valid = sl_evt;
        push_kind = sl_kind;
      end
      default: begin
        push_valid = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Link state machine
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state <= plc_st_idle;
      slave_is_b <= 1'b0;
      wake_from_a <= 1'b0;
      timer <= 20'h0_0000;
    end else begin
      case (state)
        plc_st_idle: begin
          if (wake_any) begin
            state <= plc_st_waking;
            wake_from_a <= !wake_hit[1];
            slave_is_b <= 1'b0;
            timer <= 20'h0_0000;
          end
        end
        plc_st_waking: begin
          timer <= timer + 20'h0_0001;
          if (wake_done) begin
            state <= plc_st_ready;
          end
        end
        plc_st_ready: begin
          if (idle_cnt >= 20'(IDLE_CYCLES - 1)) begin
            state <= plc_st_idle;
          end else if (four_wire && sel_fall) begin
            state <= plc_st_active;
            slave_is_b <= 1'b0;
          end else if (!four_wire && (start_a || start_b)) begin
            state <= plc_st_active;
            slave_is_b <= !start_a;
          end
        end
        plc_st_active: begin
          if (idle_cnt >= 20'(IDLE_CYCLES - 1)) begin
            state <= plc_st_idle;
          end else if (sl_evt && sl_kind == plc_long_pos) begin
            state <= plc_st_ready;
          end else if (!four_wire && ms_evt && ms_long && !ms_pos && swap_ok) begin
            slave_is_b <= !slave_is_b;
          end
        end
        default: begin
          state <= plc_st_idle;
        end
      endcase
    end
  end

  assign link_state = state;
  assign slave_on_b = slave_is_b;

  // ----------------------------------------------------------------
  // Idle and blocking timers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst || state == plc_st_idle || wake_any || rx_evt != 2'h0) begin
      idle_cnt <= 20'h0_0000;
    end else if (idle_cnt != 20'hf_ffff) begin
      idle_cnt <= idle_cnt + 20'h0_0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst || tx_busy != 2'h0) begin
      blk_cnt <= 20'h0_0000;
    end else if (!swap_ok) begin
      blk_cnt <= blk_cnt + 20'h0_0001;
    end
  end

  // ----------------------------------------------------------------
  // Internal serial bus and read decode
  // ----------------------------------------------------------------
  logic clk_pend;
  logic decide_pend;
  logic read_mode;
  logic ret_bit;
  logic ret_pend;
  logic chain_bit;
  logic [5:0] bit_cnt;
  logic short_in;

  plc_sym_if sym_a ();
  plc_sym_if sym_b ();

  assign short_in = (state == plc_st_active) && sl_evt && !plc_is_long(sl_kind);
  assign chain_bit = core_read_more ? core_read_bit : ret_bit;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      int_select_bar <= 1'b1;
      int_data <= 1'b0;
      int_clk <= 1'b0;
      clk_pend <= 1'b0;
    end else begin
      int_select_bar <= (state != plc_st_active);
      int_clk <= clk_pend;
      clk_pend <= short_in;
      if (short_in) begin
        int_data <= plc_is_pos(sl_kind);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst || state != plc_st_active) begin
      bit_cnt <= 6'h00;
      decide_pend <= 1'b0;
      read_mode <= 1'b0;
    end else begin
      decide_pend <= int_clk && (bit_cnt == 6'(`PLC_CMD_BITS));
      if (short_in && bit_cnt != 6'h3f) begin
        bit_cnt <= bit_cnt + 6'h01;
      end
      if (decide_pend) begin
        read_mode <= core_read_cmd;
      end
    end
  end

  // Return slot of the master port: silence means a one
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ret_bit <= 1'b1;
    end else if (push_valid && !plc_is_long(push_kind)) begin
      ret_bit <= 1'b1;
    end else if (ms_evt && !ms_long && !ms_pos) begin
      ret_bit <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      serial_out <= 1'b1;
      ret_pend <= 1'b0;
    end else begin
      if (four_wire && clk_rise && read_mode) begin
        serial_out <= chain_bit;
      end else if (!read_mode) begin
        serial_out <= 1'b1;
      end
      if (!four_wire && short_in && read_mode && !chain_bit) begin
        ret_pend <= 1'b1;
      end else if (slave_is_b ? sym_b.ready : sym_a.ready) begin
        ret_pend <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outgoing symbol path
  // ----------------------------------------------------------------
  logic fifo_valid;
  logic [1:0] fifo_data;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sym_dropped <= 1'b0;
    end else if (push_valid && !push_ready) begin
      sym_dropped <= 1'b1;
    end
  end

  plc_sym_fifo #(
    .WIDTH(`PLC_FIFO_WIDTH),
    .DEPTH(`PLC_FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_kind),
    .out_valid(fifo_valid),
    .out_ready(slave_is_b ? sym_a.ready : sym_b.ready),
    .out_data(fifo_data)
  );

  // Slave side only sends short negative answers
  assign sym_a.valid = slave_is_b ? fifo_valid : ret_pend;
  assign sym_a.kind = slave_is_b ? plc_sym_type'(fifo_data) : plc_short_neg;
  assign sym_b.valid = slave_is_b ? ret_pend : fifo_valid;
  assign sym_b.kind = slave_is_b ? plc_short_neg : plc_sym_type'(fifo_data);
  assign tx_busy = {sym_b.busy, sym_a.busy};

  plc_sym_tx u_tx_a (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .sym(sym_a),
    .line_p(port_a_pos_line_out),
    .line_n(port_a_neg_line_out),
    .line_oe(port_a_pos_line_oe)
  );

  plc_sym_tx u_tx_b (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .sym(sym_b),
    .line_p(port_b_pos_line_out),
    .line_n(port_b_neg_line_out),
    .line_oe(port_b_pos_line_oe)
  );

  assign port_a_neg_line_oe = port_a_pos_line_oe;
  assign port_b_neg_line_oe = port_b_pos_line_oe;
endmodule : plc_port_ctrl

// File: verif/plc_port_ctrl_assertions.sv
// Port-level checks of the pulse link port controller
`timescale 1ns/1ns
module plc_port_ctrl_assertions (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Watched ports
  input wire logic port_a_pos_line_out,
  input wire logic port_a_neg_line_out,
  input wire logic port_a_pos_line_oe,
  input wire logic port_b_pos_line_out,
  input wire logic port_b_pos_line_oe,
  input wire logic select_bar,
  input wire logic int_select_bar,
  input wire logic int_clk,
  input wire logic [1:0] link_state,
  input wire logic slave_on_b
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  property p_b_off; !port_b_pos_line_oe |-> !port_b_pos_line_out; endproperty
  a_b_off: assert property (p_b_off) else $error("b off");
  property p_b_min; $rose(port_b_pos_line_oe) |=> port_b_pos_line_oe [*5]; endproperty
  a_b_min: assert property (p_b_min) else $error("b short");
  property p_b_end; $rose(port_b_pos_line_oe) |-> ##[6:17] !port_b_pos_line_oe; endproperty
  a_b_end: assert property (p_b_end) else $error("b long");
  property p_a_slv;
    $rose(port_a_pos_line_oe) && !slave_on_b |-> port_a_neg_line_out ##3 port_a_pos_line_out;
  endproperty
  a_a_slv: assert property (p_a_slv) else $error("a slave");
  property p_sel; link_state == 2'h3 && $past(link_state) == 2'h3 |-> !int_select_bar; endproperty
  a_sel: assert property (p_sel) else $error("sel");
  property p_clk; int_clk |=> !int_clk; endproperty
  a_clk: assert property (p_clk) else $error("clk");
  property p_fall;
    $fell(select_bar) && link_state == 2'h2 |-> ##[2:6] port_b_pos_line_oe && !port_b_pos_line_out;
  endproperty
  a_fall: assert property (p_fall) else $error("fall");
  property p_idle; link_state == 2'h0 && $past(link_state) == 2'h0 |-> !port_b_pos_line_oe; endproperty
  a_idle: assert property (p_idle) else $error("idle");
  c_swap: cover property ($fell(slave_on_b));
  c_act: cover property (link_state == 2'h3);
  c_clk: cover property (int_clk);
endmodule : plc_port_ctrl_assertions

// File: verif/plc_far_model.sv
// Far-side pulse link device model
`timescale 1ns/1ns
module plc_far_model
  import plc_pkg::*;
(
  // Pair from the controller
  input wire logic ref_clk,
  input wire logic rx_p,
  input wire logic rx_oe,
  // Pair toward the controller
  input wire logic answer,
  output logic tx_p = 1'b0,
  output logic tx_n = 1'b0,
  // Decoded symbols
  output plc_sym_type kind,
  output logic [7:0] count = 8'h00
);
  logic first_pos;
  int len = 0;
  task automatic send(input logic is_long, input logic is_pos);
    @(posedge ref_clk);
    tx_p <= is_pos;
    tx_n <= !is_pos;
    repeat (is_long ? 8 : 3) @(posedge ref_clk);
    tx_p <= !is_pos;
    tx_n <= is_pos;
    repeat (is_long ? 8 : 3) @(posedge ref_clk);
    tx_p <= 1'b0; // Terminated pair rests at 0V
    tx_n <= 1'b0;
  endtask : send
  always @(posedge ref_clk) begin
    if (rx_oe) begin
      if (len == 0) first_pos <= rx_p;
      len <= len + 1;
    end else if (len > 0) begin
      kind <= first_pos ? (len >= 10 ? plc_long_pos : plc_short_pos)
                        : (len >= 10 ? plc_long_neg : plc_short_neg);
      count <= count + 8'h01;
      len <= 0;
      if (answer && len < 10) send(1'b0, 1'b0);
    end
  end
endmodule : plc_far_model

// File: verif/plc_port_ctrl_tb.sv
// Self-checking bench of the pulse link port controller
`timescale 1ns/1ns
module plc_port_ctrl_tb;
  import plc_pkg::*;
  logic ref_clk, sys_rst, mode, sel_bar, sclk, sin, sout, isel, idat, stby, rcmd, rmore, rbit;
  logic slv_b, ans_b, apo, ape, ano, ane, bpo, bpe, bno, bne, map, man, mbp, mbn;
  logic [1:0] state;
  logic [7:0] cnt_a;
  plc_sym_type kind_a, kind_b;
  int fails = 0;
  int cmp_count = 0;
  plc_port_ctrl #(.IDLE_CYCLES(400), .WAKE_CYCLES(40), .READY_CYCLES(20), .BLOCK_CYCLES(30))
      plc_port_ctrl_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .port_a_pos_line_in(ape ? apo : map), .port_a_pos_line_out(apo), .port_a_pos_line_oe(ape),
    .port_a_neg_line_in(ane ? ano : man), .port_a_neg_line_out(ano), .port_a_neg_line_oe(ane),
    .port_b_pos_line_in(bpe ? bpo : mbp), .port_b_pos_line_out(bpo), .port_b_pos_line_oe(bpe),
    .port_b_neg_line_in(bne ? bno : mbn), .port_b_neg_line_out(bno), .port_b_neg_line_oe(bne),
    .port_a_mode_select(mode), .select_bar(sel_bar), .serial_clk(sclk), .serial_in(sin),
    .serial_out(sout), .int_select_bar(isel), .int_clk(), .int_data(idat), .core_standby(stby),
    .core_read_cmd(rcmd), .core_read_more(rmore), .core_read_bit(rbit), .link_state(state),
    .slave_on_b(slv_b), .sym_dropped());
  plc_far_model plc_far_model_a_i (.ref_clk(ref_clk), .rx_p(apo), .rx_oe(ape), .answer(1'b0),
    .tx_p(map), .tx_n(man), .kind(kind_a), .count(cnt_a));
  plc_far_model plc_far_model_b_i (.ref_clk(ref_clk), .rx_p(bpo), .rx_oe(bpe), .answer(ans_b),
    .tx_p(mbp), .tx_n(mbn), .kind(kind_b), .count());
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc
  task automatic chk(input string what, input logic [1:0] exp, input logic [1:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic fw_bit(input logic b);
    sin <= b;
    cyc(8);
    sclk <= 1'b1;
    cyc(14);
    sclk <= 1'b0;
    cyc(4);
  endtask : fw_bit
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report
  task automatic t_wake_fw();
    sel_bar <= 1'b0;
    cyc(4);
    sel_bar <= 1'b1;
    cyc(30);
    chk("state", 2'h1, state);
    cyc(40);
    chk("state", 2'h2, state);
    chk("kind b", plc_long_pos, kind_b);
    $display("wake test done");
  endtask : t_wake_fw
  task automatic t_fw_read();
    logic [31:0] pat;
    pat = 32'hA5C3_0F96;
    sel_bar <= 1'b0;
    cyc(22);
    chk("kind b", plc_long_neg, kind_b);
    chk("state", 2'h3, state);
    chk("int select", 1'b0, isel);
    rcmd <= 1'b1;
    rmore <= 1'b1;
    for (int i = 31; i >= 0; i--) begin
      fw_bit(pat[i]);
      chk("kind b", pat[i] ? plc_short_pos : plc_short_neg, kind_b);
      chk("int data", pat[i], idat);
    end
    for (int i = 0; i < 4; i++) begin
      rbit <= i[0];
      fw_bit(1'b0);
      chk("serial out", i[0], sout);
    end
    rmore <= 1'b0;
    ans_b <= 1'b1;
    repeat (3) fw_bit(1'b0);
    chk("serial out", 1'b0, sout);
    ans_b <= 1'b0;
    repeat (3) fw_bit(1'b0);
    chk("serial out", 1'b1, sout);
    sel_bar <= 1'b1;
    rcmd <= 1'b0;
    cyc(22);
    chk("kind b", plc_long_pos, kind_b);
    chk("state", 2'h2, state);
    $display("read test done");
  endtask : t_fw_read
  task automatic t_roles();
    mode <= 1'b1;
    cyc(6);
    plc_far_model_b_i.send(1'b1, 1'b0);
    cyc(6);
    chk("slave b", 1'b1, slv_b);
    plc_far_model_b_i.send(1'b0, 1'b1);
    cyc(20);
    chk("int data", 1'b1, idat);
    chk("kind a", plc_short_pos, kind_a);
    plc_far_model_a_i.send(1'b1, 1'b0);
    cyc(6);
    chk("slave b", 1'b1, slv_b);
    cyc(40);
    plc_far_model_a_i.send(1'b1, 1'b0);
    cyc(6);
    chk("slave b", 1'b0, slv_b);
    plc_far_model_a_i.send(1'b1, 1'b1);
    cyc(6);
    chk("state", 2'h2, state);
    $display("role test done");
  endtask : t_roles
  task automatic t_wake_b();
    logic [7:0] cnt;
    cyc(440);
    chk("state", 2'h0, state);
    plc_far_model_b_i.send(1'b0, 1'b1);
    cyc(20);
    chk("state", 2'h0, state);
    stby <= 1'b1;
    cnt = cnt_a;
    plc_far_model_b_i.send(1'b1, 1'b1);
    cyc(30);
    chk("state", 2'h2, state);
    cyc(30);
    chk("count a", 2'h0, 2'(cnt_a - cnt));
    $display("wake b test done");
  endtask : t_wake_b
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    {mode, sclk, sin, stby, rcmd, rmore, rbit, ans_b} = 8'h00;
    sel_bar = 1'b1;
    sys_rst = 1'b1;
    cyc(2);
    sys_rst <= 1'b0;
    cyc(6);
    t_wake_fw();
    t_fw_read();
    t_roles();
    t_wake_b();
    final_report();
  end
  initial begin
    cyc(4000);
    fails++;
    final_report();
  end
endmodule : plc_port_ctrl_tb
bind plc_port_ctrl plc_port_ctrl_assertions plc_port_ctrl_assertions_i (.*);
